//--- src/als_stop_top.sv
/*
 * Locking stop command for one axis: AXI4-Lite register file, start edge
 * sequencer, ramp to zero speed, axis lock and sticky interrupts.
 * Assumes one clock; the trajectory generator and peer requests share it.
 */
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "als_params.svh"

module als_stop_top
    import als_pkg::*;
#(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // AXI4-Lite write address
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    // AXI4-Lite write data
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    // AXI4-Lite write response
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read address
    input wire logic [AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    // AXI4-Lite read data
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Trajectory generator side
    input wire logic [31:0] i_axis_speed,
    input wire logic i_peer_stop_req,
    output logic [31:0] o_speed_cmd,
    output logic o_vel_abort,
    output logic o_at_speed_clr,
    output logic o_axis_lock,
    // Command status
    output logic o_done,
    output logic o_busy,
    output logic o_active,
    output logic o_aborted,
    output logic o_error,
    output logic [15:0] o_fault_code,
    output logic o_irq
);

    // Register file and bus state
    logic exec_q, exec_d;
    logic [31:0] decel_q, decel_d, jerk_q, jerk_d;
    logic [2:0] mask_q, mask_d, stat_q, stat_d;
    logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // Sequencer state
    als_state_type state_q, state_d;
    logic exec_prev_q, exec_prev_d;
    logic [31:0] dec_lat_q, dec_lat_d, jerk_lat_q, jerk_lat_d;
    logic [15:0] code_q, code_d;
    logic vabort_q, vabort_d;
    logic start, params_ok, ramp_load, ramp_zero;
    logic [31:0] ramp_init, ramp_speed, status_word;
    logic [2:0] events;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] als_wmerge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : als_wmerge

    // Edge detection on execute and parameter sanity
    assign start = exec_q && !exec_prev_q;
    assign params_ok = (decel_q != '0) && (jerk_q != '0);

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        exec_prev_d = exec_q;
        dec_lat_d = dec_lat_q;
        jerk_lat_d = jerk_lat_q;
        code_d = code_q;
        vabort_d = 1'b0;
        ramp_load = 1'b0;
        ramp_init = i_axis_speed;
        if (start) begin
            if (!params_ok) begin
                state_d = st_fault;
                code_d = (decel_q == '0) ? `ALS_FAULT_DECEL : `ALS_FAULT_JERK;
            end else begin
                state_d = st_stopping;
                dec_lat_d = decel_q;
                jerk_lat_d = jerk_q;
                code_d = `ALS_FAULT_NONE;
                ramp_load = 1'b1;
                if (state_q == st_stopping) begin
                    ramp_init = ramp_speed;
                end else begin
                    vabort_d = 1'b1;
                end
            end
        end else begin
            unique case (state_q)
                st_idle: begin
                end
                // Execute is not looked at here, so dropping it changes nothing
                st_stopping: begin
                    if (i_peer_stop_req) begin
                        state_d = st_aborted;
                    end else if (ramp_zero) begin
                        state_d = st_done;
                    end
                end
                st_done, st_aborted, st_fault: begin
                    if (!exec_q) begin
                        state_d = st_idle;
                    end
                end
                // Three codes of the state word are unused; fall back to idle
                default: begin
                    state_d = st_idle;
                end
            endcase
        end
        events = '0;
        events[`ALS_IRQ_DONE] = (state_d == st_done) && (state_q != st_done);
        events[`ALS_IRQ_ABORT] = (state_d == st_aborted) && (state_q != st_aborted);
        events[`ALS_IRQ_ERROR] = (state_d == st_fault) && (state_q != st_fault);
    end

    // Sequencer registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= st_idle;
            exec_prev_q <= 1'b0;
            dec_lat_q <= `ALS_RST_DECEL;
            jerk_lat_q <= `ALS_RST_JERK;
            code_q <= `ALS_FAULT_NONE;
            vabort_q <= 1'b0;
        end else begin
            state_q <= state_d;
            exec_prev_q <= exec_prev_d;
            dec_lat_q <= dec_lat_d;
            jerk_lat_q <= jerk_lat_d;
            code_q <= code_d;
            vabort_q <= vabort_d;
        end
    end

    // Speed profile runs only in the stopping state
    als_ramp #(
        .W(32)
    ) u_ramp (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_load(ramp_load),
        .i_run(state_q == st_stopping),
        .i_speed(ramp_init),
        .i_decel(dec_lat_q),
        .i_jerk(jerk_lat_q),
        .o_speed(ramp_speed),
        .o_zero(ramp_zero)
    );

    // Command outputs, all decoded from flops
    assign o_busy = (state_q == st_stopping);
    assign o_active = (state_q == st_stopping);
    assign o_done = (state_q == st_done);
    assign o_aborted = (state_q == st_aborted);
    assign o_error = (state_q == st_fault);
    assign o_fault_code = code_q;
    assign o_speed_cmd = ramp_speed;
    assign o_vel_abort = vabort_q;
    assign o_at_speed_clr = vabort_q;
    // Lock covers the stop itself and the stopped axis until execute drops
    assign o_axis_lock = o_busy || (o_done && exec_q);
    assign o_irq = |(stat_q & mask_q);

    // Status word seen by software
    always_comb begin
        status_word = '0;
        status_word[`ALS_ST_DONE] = o_done;
        status_word[`ALS_ST_BUSY] = o_busy;
        status_word[`ALS_ST_ACTIVE] = o_active;
        status_word[`ALS_ST_ABORT] = o_aborted;
        status_word[`ALS_ST_ERROR] = o_error;
        status_word[`ALS_ST_LOCK] = o_axis_lock;
        status_word[`ALS_ST_CODE_LSB +: 16] = code_q;
    end

    // Bus handshakes: one write and one read in flight at a time
    assign o_awready = !aw_ok_q && !bvalid_q;
    assign o_wready = !w_ok_q && !bvalid_q;
    assign o_arready = !rvalid_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rresp = rresp_q;
    assign o_rdata = rdata_q;

    // Register file next values
    always_comb begin
        logic rd_clr;
        logic [31:0] tmp;
        rd_clr = 1'b0;
        tmp = '0;
        exec_d = exec_q;
        decel_d = decel_q;
        jerk_d = jerk_q;
        mask_d = mask_q;
        aw_ok_d = aw_ok_q;
        awaddr_d = awaddr_q;
        w_ok_d = w_ok_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (i_awvalid && o_awready) begin
            aw_ok_d = 1'b1;
            awaddr_d = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            w_ok_d = 1'b1;
            wdata_d = i_wdata;
            wstrb_d = i_wstrb;
        end
        // Address and data may arrive in either order; commit once both held
        if (aw_ok_q && w_ok_q) begin
            aw_ok_d = 1'b0;
            w_ok_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `ALS_RESP_OKAY;
            case (awaddr_q)
                `ALS_REG_CTRL: begin
                    tmp = als_wmerge({31'h0, exec_q}, wdata_q, wstrb_q);
                    exec_d = tmp[`ALS_CTRL_EXEC];
                end
                `ALS_REG_DECEL: decel_d = als_wmerge(decel_q, wdata_q, wstrb_q);
                `ALS_REG_JERK: jerk_d = als_wmerge(jerk_q, wdata_q, wstrb_q);
                `ALS_REG_IRQ_MASK: begin
                    tmp = als_wmerge({29'h0, mask_q}, wdata_q, wstrb_q);
                    mask_d = tmp[2:0];
                end
                `ALS_REG_STATUS, `ALS_REG_SPEED, `ALS_REG_IRQ_STAT: begin
                end
                default: bresp_d = `ALS_RESP_SLVERR;
            endcase
        end
        if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            rvalid_d = 1'b1;
            rresp_d = `ALS_RESP_OKAY;
            case (i_araddr)
                `ALS_REG_CTRL: rdata_d = {31'h0, exec_q};
                `ALS_REG_DECEL: rdata_d = decel_q;
                `ALS_REG_JERK: rdata_d = jerk_q;
                `ALS_REG_STATUS: rdata_d = status_word;
                `ALS_REG_SPEED: rdata_d = ramp_speed;
                `ALS_REG_IRQ_STAT: begin
                    rdata_d = {29'h0, stat_q};
                    rd_clr = 1'b1;
                end
                `ALS_REG_IRQ_MASK: rdata_d = {29'h0, mask_q};
                default: begin
                    rdata_d = '0;
                    rresp_d = `ALS_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && i_rready) begin
            rvalid_d = 1'b0;
        end
        // Read clears, but an event in the same cycle survives it
        stat_d = (rd_clr ? 3'h0 : stat_q) | events;
    end

    // Register file registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            exec_q <= 1'b0;
            decel_q <= `ALS_RST_DECEL;
            jerk_q <= `ALS_RST_JERK;
            mask_q <= `ALS_RST_MASK;
            stat_q <= 3'h0;
            aw_ok_q <= 1'b0;
            awaddr_q <= '0;
            w_ok_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= `ALS_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= `ALS_RESP_OKAY;
            rdata_q <= '0;
        end else begin
            exec_q <= exec_d;
            decel_q <= decel_d;
            jerk_q <= jerk_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            aw_ok_q <= aw_ok_d;
            awaddr_q <= awaddr_d;
            w_ok_q <= w_ok_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    a_level_idle: assert property (
        state_q == st_idle && !start |=> !o_busy && !o_done)
        else $error("held execute level changed the command");
    a_drop_ignored: assert property (
        o_busy && !exec_q && !i_peer_stop_req && !ramp_zero |=> o_busy)
        else $error("execute drop disturbed the stop");
    a_restart_sample: assert property (
        start && o_busy && params_ok |=> o_busy && dec_lat_q == $past(decel_q)
            && jerk_lat_q == $past(jerk_q))
        else $error("restart did not re-sample decel and jerk");
    a_start_busy: assert property (
        start && params_ok |=> o_busy && o_active)
        else $error("busy and active did not rise after start");
    a_done_edge: assert property (
        o_busy && !start && !i_peer_stop_req && ramp_zero
            |=> o_done && !o_busy && !o_active && o_speed_cmd == '0)
        else $error("done and busy did not swap at zero speed");
    a_done_hold: assert property (
        o_done && exec_q |=> o_done)
        else $error("done cleared while execute high");
    a_done_clear: assert property (
        o_done && !exec_q |=> !o_done ##1 !o_done)
        else $error("done stayed after execute low");
    a_abort_set: assert property (
        o_busy && i_peer_stop_req && !start |=> o_aborted && !o_busy)
        else $error("interrupt did not raise aborted");
    a_abort_hold: assert property (
        o_aborted && exec_q |=> o_aborted)
        else $error("aborted cleared while execute high");
    a_lock_held: assert property (
        (o_busy || (o_done && exec_q)) |-> o_axis_lock)
        else $error("axis unlocked while stop owns it");
    a_lock_release: assert property (
        $fell(exec_q) && o_done |-> !o_axis_lock ##1 !o_axis_lock)
        else $error("axis still locked after execute dropped");
    a_vel_abort: assert property (
        start && params_ok && !o_busy |=> o_vel_abort && o_at_speed_clr ##1 !o_vel_abort)
        else $error("velocity move not aborted on start");
    a_fault_code: assert property (
        start && decel_q == '0 |=> o_error && o_fault_code == `ALS_FAULT_DECEL && !o_busy)
        else $error("zero decel did not raise fault");

endmodule : als_stop_top

//--- src/als_params.svh
/*
 * Constants of the locking stop command block: register byte offsets,
 * field positions, reset values, fault codes and bus responses.
 * Assumes inclusion by bare name from the package and the block's modules.
 */
`ifndef ALS_PARAMS_SVH
`define ALS_PARAMS_SVH

// Register byte offsets, one aligned word each
`define ALS_REG_CTRL 8'h00
`define ALS_REG_DECEL 8'h04
`define ALS_REG_JERK 8'h08
`define ALS_REG_STATUS 8'h0c
`define ALS_REG_SPEED 8'h10
`define ALS_REG_IRQ_STAT 8'h14
`define ALS_REG_IRQ_MASK 8'h18

// Field positions
`define ALS_CTRL_EXEC 0
`define ALS_ST_DONE 0
`define ALS_ST_BUSY 1
`define ALS_ST_ACTIVE 2
`define ALS_ST_ABORT 3
`define ALS_ST_ERROR 4
`define ALS_ST_LOCK 5
`define ALS_ST_CODE_LSB 16
`define ALS_IRQ_DONE 0
`define ALS_IRQ_ABORT 1
`define ALS_IRQ_ERROR 2

// Reset values
`define ALS_RST_DECEL 32'h0000_0000
`define ALS_RST_JERK 32'h0000_0000
`define ALS_RST_MASK 3'h0

// Fault codes
`define ALS_FAULT_NONE 16'h0000
`define ALS_FAULT_DECEL 16'h0001
`define ALS_FAULT_JERK 16'h0002

// Bus responses
`define ALS_RESP_OKAY 2'h0
`define ALS_RESP_SLVERR 2'h2

`endif

//--- src/als_pkg.sv
/*
 * Types of the locking stop command block.
 * Assumes nothing beyond the constants header.
 */
`include "als_params.svh"

package als_pkg;

    // Command sequencer states
    typedef enum logic [2:0] {
        st_idle,
        st_stopping,
        st_done,
        st_aborted,
        st_fault
    } als_state_type;

endpackage : als_pkg

//--- src/als_ramp.sv
/*
 * Jerk limited speed ramp down to zero.
 * Assumes the caller holds i_decel and i_jerk steady while i_run is high
 * and never runs it with a zero jerk.
 */
`include "als_params.svh"

module als_ramp
    import als_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_load,
    input wire logic i_run,
    // Profile inputs
    input wire logic [W-1:0] i_speed,
    input wire logic [W-1:0] i_decel,
    input wire logic [W-1:0] i_jerk,
    // Profile outputs
    output logic [W-1:0] o_speed,
    output logic o_zero
);

    logic [W-1:0] speed_q, speed_d, rate_q, rate_d;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Rate grows by jerk per cycle up to decel, so the braking starts soft
    always_comb begin
        speed_d = speed_q;
        rate_d = rate_q;
        if (i_load) begin
            speed_d = i_speed;
            rate_d = '0;
        end else if (i_run) begin
            if (i_decel - rate_q > i_jerk) begin
                rate_d = rate_q + i_jerk;
            end else begin
                rate_d = i_decel;
            end
            speed_d = (speed_q > rate_d) ? speed_q - rate_d : '0;
        end
    end

    // Profile registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            speed_q <= '0;
            rate_q <= '0;
        end else begin
            speed_q <= speed_d;
            rate_q <= rate_d;
        end
    end

    assign o_speed = speed_q;
    assign o_zero = (speed_q == '0);

    a_ramp_falls: assert property (
        i_run && !i_load && speed_q != '0 && i_jerk != '0 |=> speed_q < $past(speed_q))
        else $error("speed did not fall while ramping");

    a_rate_bound: assert property (
        i_run && !i_load |=> rate_q <= $past(i_decel)
            && rate_q - $past(rate_q) <= $past(i_jerk))
        else $error("braking rate broke its decel or jerk bound");

endmodule : als_ramp

//--- verification/als_traj_model.sv
/*
 * Trajectory generator stand-in: one velocity move, a locked axis refusing
 * new moves, and a peer stop request passed through from the bench.
 * Assumes the stop block's clock and reset.
 */
module als_traj_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // From the stop block
    input wire logic i_vel_abort,
    input wire logic i_at_speed_clr,
    input wire logic i_axis_lock,
    // From the bench
    input wire logic i_move_go,
    input wire logic i_peer_go,
    // To the stop block; o_in_vel to the bench
    output logic [31:0] o_axis_speed,
    output logic o_peer_stop_req,
    output logic o_in_vel
);
    timeunit 1ns;
    timeprecision 1ps;

    // Abort wins over a new move request in the same cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_in_vel <= 1'b0;
        end else if (i_vel_abort || i_at_speed_clr) begin
            o_in_vel <= 1'b0;
        end else if (i_move_go && !i_axis_lock) begin
            o_in_vel <= 1'b1;
        end
    end

    // Full speed only while moving
    assign o_axis_speed = o_in_vel ? 32'h0000_03e8 : 32'h0000_0000;
    assign o_peer_stop_req = i_peer_go;
endmodule : als_traj_model

//--- verification/als_stop_top_tb_top.sv
/*
 * Bench for the locking stop block: AXI4-Lite register tasks and command
 * sequences with expected values.
 * Assumes the design sources and the trajectory model are compiled first.
 */
`include "als_params.svh"

module als_stop_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk, i_resetn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, move_go = 1'b0, peer_go = 1'b0, chk_en = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, axis_speed, o_speed_cmd, e, r, dec_v, jrk_v, v;
    logic [3:0] i_wstrb = 4'h0;
    logic [1:0] o_bresp, o_rresp, resp;
    logic [15:0] o_fault_code;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, peer_req, o_vel_abort;
    logic o_at_speed_clr, o_axis_lock, o_done, o_busy, o_active, o_aborted, o_error;
    logic o_irq, in_vel;
    int n_errors = 0, n_checks = 0, n_ab = 0;

    als_stop_top #(.AW(8)) als_stop_top_inst (
        .i_clk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_axis_speed(axis_speed),
        .i_peer_stop_req(peer_req), .o_speed_cmd, .o_vel_abort, .o_at_speed_clr,
        .o_axis_lock, .o_done, .o_busy, .o_active, .o_aborted, .o_error, .o_fault_code, .o_irq
    );
    als_traj_model als_traj_model_inst (
        .i_clk, .i_resetn, .i_vel_abort(o_vel_abort), .i_at_speed_clr(o_at_speed_clr),
        .i_axis_lock(o_axis_lock), .i_move_go(move_go), .i_peer_go(peer_go),
        .o_axis_speed(axis_speed), .o_peer_stop_req(peer_req), .o_in_vel(in_vel)
    );

    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] s);
        n_checks++;
        if (s !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, ex, s);
        end
    endtask : chk

    task automatic hang(input string n);
        n_errors++;
        $display("wrong value %s expected answer seen none", n);
        complete_run();
    endtask : hang

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        i_awaddr <= a;
        i_awvalid <= 1'b1;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1) break;
        end
        if (k == 50) hang("write response");
        i_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int k;
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1) break;
        end
        if (k == 50) hang("read data");
        d = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] d;
        rd(a, d);
        chk($sformatf("register %h", a), ex, d);
    endtask : rc

    task automatic wait_done();
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge i_clk);
            if (o_done === 1'b1) break;
        end
        if (k == 300) hang("done");
    endtask : wait_done

    task automatic move();
        @(posedge i_clk);
        move_go <= 1'b1;
        @(posedge i_clk);
        move_go <= 1'b0;
        @(posedge i_clk);
    endtask : move

    // Ramp model runs only where no restart disturbs it
    always @(posedge i_clk) begin
        if (i_resetn) begin
            if (o_vel_abort === 1'b1) n_ab++;
            if (o_vel_abort !== o_at_speed_clr) chk("speed flag clear", o_vel_abort, o_at_speed_clr);
            if (o_busy !== o_active) chk("active", o_busy, o_active);
            if (o_busy === 1'b1 && chk_en) begin
                if (o_vel_abort === 1'b1) begin
                    e = 32'h3e8;
                    r = 32'h0;
                end
                chk("speed", e, o_speed_cmd);
                r = (r + jrk_v > dec_v) ? dec_v : r + jrk_v;
                e = (e > r) ? e - r : 32'h0;
            end
        end
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        rc(`ALS_REG_STATUS, 32'h0);
        rc(`ALS_REG_DECEL, `ALS_RST_DECEL);
        rc(`ALS_REG_IRQ_MASK, 32'h0);
        rd(8'h40, v);
        chk("unmapped response", {30'h0, `ALS_RESP_SLVERR}, {30'h0, resp});
        wr(`ALS_REG_IRQ_MASK, 32'h7);
        rc(`ALS_REG_IRQ_MASK, 32'h7);
        // Full stop from a running move, execute held
        dec_v = 32'd100;
        jrk_v = 32'd20;
        chk_en = 1'b1;
        wr(`ALS_REG_DECEL, dec_v);
        wr(`ALS_REG_JERK, jrk_v);
        move();
        wr(`ALS_REG_CTRL, 32'h1);
        wait_done();
        chk("busy at done", 0, o_busy);
        chk("aborts", 1, n_ab);
        chk("move running", 0, in_vel);
        repeat (3) @(posedge i_clk);
        chk("done held", 1, o_done);
        chk("irq", 1, o_irq);
        rc(`ALS_REG_IRQ_STAT, 32'h1);
        rc(`ALS_REG_IRQ_STAT, 32'h0);
        chk("irq cleared", 0, o_irq);
        wr(`ALS_REG_CTRL, 32'h1);
        rc(`ALS_REG_STATUS, 32'h21);
        move();
        chk("refused move", 0, in_vel);
        wr(`ALS_REG_CTRL, 32'h0);
        rc(`ALS_REG_STATUS, 32'h0);
        move();
        chk("released move", 1, in_vel);
        // Peer stop takes the axis
        wr(`ALS_REG_CTRL, 32'h1);
        @(posedge i_clk);
        peer_go <= 1'b1;
        @(posedge i_clk);
        peer_go <= 1'b0;
        rc(`ALS_REG_STATUS, 32'h8);
        rc(`ALS_REG_IRQ_STAT, 32'h2);
        wr(`ALS_REG_CTRL, 32'h0);
        rc(`ALS_REG_STATUS, 32'h0);
        // Execute dropped mid-stop, then a restart
        chk_en = 1'b0;
        wr(`ALS_REG_JERK, 32'h1);
        move();
        wr(`ALS_REG_CTRL, 32'h1);
        wr(`ALS_REG_CTRL, 32'h0);
        rc(`ALS_REG_STATUS, 32'h26);
        wr(`ALS_REG_DECEL, 32'd200);
        wr(`ALS_REG_CTRL, 32'h1);
        chk("restart aborts", 3, n_ab);
        wr(`ALS_REG_CTRL, 32'h0);
        wait_done();
        @(posedge i_clk);
        chk("done pulse", 0, o_done);
        rc(`ALS_REG_IRQ_STAT, 32'h1);
        // Bad parameters, interrupt masked
        wr(`ALS_REG_IRQ_MASK, 32'h0);
        wr(`ALS_REG_DECEL, 32'h0);
        wr(`ALS_REG_CTRL, 32'h1);
        rc(`ALS_REG_STATUS, {`ALS_FAULT_DECEL, 16'h0010});
        chk("masked irq", 0, o_irq);
        rc(`ALS_REG_IRQ_STAT, 32'h4);
        wr(`ALS_REG_CTRL, 32'h0);
        wr(`ALS_REG_DECEL, 32'd100);
        wr(`ALS_REG_JERK, 32'h0);
        wr(`ALS_REG_CTRL, 32'h1);
        rc(`ALS_REG_STATUS, {`ALS_FAULT_JERK, 16'h0010});
        chk("fault code", {16'h0, `ALS_FAULT_JERK}, {16'h0, o_fault_code});
        wr(`ALS_REG_CTRL, 32'h0);
        rc(`ALS_REG_STATUS, {`ALS_FAULT_JERK, 16'h0000});
        complete_run();
    end
endmodule : als_stop_top_tb_top
